// [bst_pkg.sv]
// shared constants and types for the boundary scan test port
package bst_pkg;
	localparam int              IR_W        = 4;
	localparam logic [IR_W-1:0] INS_EXTEST  = 4'h0;
	localparam logic [IR_W-1:0] INS_IDCODE  = 4'h1;
	localparam logic [IR_W-1:0] INS_SAMPLE  = 4'h2;
	localparam logic [IR_W-1:0] INS_BYPASS  = 4'hf;
	localparam logic [IR_W-1:0] IR_CAPTURE  = 4'h1;
	localparam int              ID_W        = 32;
	// arbitrary identity value, bit 0 set as scan chains expect
	localparam logic [ID_W-1:0] ID_DEFAULT  = 32'h1000_0001;
	localparam int              BSR_LEN     = 8;
	localparam int              PIN_N       = 4;
	localparam int              PIN_TCK     = 0;
	localparam int              PIN_TMS     = 1;
	localparam int              PIN_TDI     = 2;
	localparam int              PIN_TRST    = 3;
	localparam logic [PIN_N-1:0] PIN_RESET  = 4'h8;

	typedef enum logic [15:0]
	{
		S_TLR   = 16'h0001,
		S_RTI   = 16'h0002,
		S_SELDR = 16'h0004,
		S_CAPDR = 16'h0008,
		S_SHDR  = 16'h0010,
		S_EX1DR = 16'h0020,
		S_PAUDR = 16'h0040,
		S_EX2DR = 16'h0080,
		S_UPDR  = 16'h0100,
		S_SELIR = 16'h0200,
		S_CAPIR = 16'h0400,
		S_SHIR  = 16'h0800,
		S_EX1IR = 16'h1000,
		S_PAUIR = 16'h2000,
		S_EX2IR = 16'h4000,
		S_UPIR  = 16'h8000
	} bst_state_t;
endpackage

// [bst_pin_if.sv]
// synchronised test pin events passed from the sampler to the tap
`timescale 1ns/100ps
interface bst_pin_if;
	logic tckRise;
	logic tckFall;
	logic tms;
	logic tdi;
	logic trstN;

	modport drive
	(
		output tckRise,
		output tckFall,
		output tms,
		output tdi,
		output trstN
	);
	modport tap
	(
		input tckRise,
		input tckFall,
		input tms,
		input tdi,
		input trstN
	);
endinterface

// [bst_pin_sync.sv]
// two-stage pin sampler and test clock edge finder
`timescale 1ns/100ps
module bst_pin_sync
	import bst_pkg::*;
(
	// system
	input  wire logic   clk,
	input  wire logic   reset,
	// raw test pins
	input  wire logic   tckPin,
	input  wire logic   tmsPin,
	input  wire logic   tdiPin,
	input  wire logic   trstPinN,
	// events toward the tap
	bst_pin_if.drive    pinsOut
);
	logic [PIN_N-1:0] rawPins;
	logic [PIN_N-1:0] meta_q;
	logic [PIN_N-1:0] meta_d;
	logic [PIN_N-1:0] stab_q;
	logic [PIN_N-1:0] stab_d;
	logic             tckLast_q;
	logic             tckLast_d;

	assign rawPins = {trstPinN, tdiPin, tmsPin, tckPin};

	// first stage feeds only the second; edges come from stage two
	always_comb
	begin
		meta_d    = rawPins;
		stab_d    = meta_q;
		tckLast_d = stab_q[PIN_TCK];
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta_q    <= PIN_RESET;
			stab_q    <= PIN_RESET;
			tckLast_q <= 1'b0;
		end
		else
		begin
			meta_q    <= meta_d;
			stab_q    <= stab_d;
			tckLast_q <= tckLast_d;
		end
	end

	assign pinsOut.tckRise = stab_q[PIN_TCK] & ~tckLast_q;
	assign pinsOut.tckFall = ~stab_q[PIN_TCK] & tckLast_q;
	assign pinsOut.tms     = stab_q[PIN_TMS];
	assign pinsOut.tdi     = stab_q[PIN_TDI];
	assign pinsOut.trstN   = stab_q[PIN_TRST];
endmodule

// [bst_tap_port.sv]
// boundary scan test access port controller, sampled on the system clock
`timescale 1ns/100ps
module bst_tap_port
	import bst_pkg::*;
#(
	parameter logic [ID_W-1:0] ID_VALUE = ID_DEFAULT,
	parameter int              BSR_W    = BSR_LEN
)
(
	// system
	input  wire logic             clk,
	input  wire logic             reset,
	// test pins from the scan controller
	input  wire logic             tckPin,
	input  wire logic             tmsPin,
	input  wire logic             tdiPin,
	input  wire logic             trstPinN,
	// test data out, three-state
	output logic                  tdoOut,
	output logic                  tdoOeN,
	// boundary cells
	input  wire logic [BSR_W-1:0] bsrSense,
	output logic [BSR_W-1:0]      bsrDrive,
	output logic                  extestActive
);
	bst_pin_if pins();

	bst_state_t       state_q;
	bst_state_t       state_d;
	logic [IR_W-1:0]  ir_q;
	logic [IR_W-1:0]  ir_d;
	logic [IR_W-1:0]  irSh_q;
	logic [IR_W-1:0]  irSh_d;
	logic             bypass_q;
	logic             bypass_d;
	logic [ID_W-1:0]  idSh_q;
	logic [ID_W-1:0]  idSh_d;
	logic [BSR_W-1:0] bsrSh_q;
	logic [BSR_W-1:0] bsrSh_d;
	logic [BSR_W-1:0] bsrDrive_q;
	logic [BSR_W-1:0] bsrDrive_d;
	logic             tdo_q;
	logic             tdo_d;
	logic             tdoOeN_q;
	logic             tdoOeN_d;
	logic             extest_q;
	logic             extest_d;
	logic             drLsb;

	bst_pin_sync u_sync
	(
		.clk      (clk),
		.reset    (reset),
		.tckPin   (tckPin),
		.tmsPin   (tmsPin),
		.tdiPin   (tdiPin),
		.trstPinN (trstPinN),
		.pinsOut  (pins)
	);

	function automatic bst_state_t stepState(input bst_state_t s,
		input logic tms);
		case (s)
			S_TLR:   stepState = tms ? S_TLR   : S_RTI;
			S_RTI:   stepState = tms ? S_SELDR : S_RTI;
			S_SELDR: stepState = tms ? S_SELIR : S_CAPDR;
			S_CAPDR: stepState = tms ? S_EX1DR : S_SHDR;
			S_SHDR:  stepState = tms ? S_EX1DR : S_SHDR;
			S_EX1DR: stepState = tms ? S_UPDR  : S_PAUDR;
			S_PAUDR: stepState = tms ? S_EX2DR : S_PAUDR;
			S_EX2DR: stepState = tms ? S_UPDR  : S_SHDR;
			S_UPDR:  stepState = tms ? S_SELDR : S_RTI;
			S_SELIR: stepState = tms ? S_TLR   : S_CAPIR;
			S_CAPIR: stepState = tms ? S_EX1IR : S_SHIR;
			S_SHIR:  stepState = tms ? S_EX1IR : S_SHIR;
			S_EX1IR: stepState = tms ? S_UPIR  : S_PAUIR;
			S_PAUIR: stepState = tms ? S_EX2IR : S_PAUIR;
			S_EX2IR: stepState = tms ? S_UPIR  : S_SHIR;
			S_UPIR:  stepState = tms ? S_SELDR : S_RTI;
			default: stepState = S_TLR;
		endcase
	endfunction

	// unknown codes fall back to the one-bit bypass path
	always_comb
	begin
		case (ir_q)
			INS_IDCODE: drLsb = idSh_q[0];
			INS_SAMPLE: drLsb = bsrSh_q[0];
			INS_EXTEST: drLsb = bsrSh_q[0];
			default:    drLsb = bypass_q;
		endcase
	end

	always_comb
	begin
		state_d    = state_q;
		ir_d       = ir_q;
		irSh_d     = irSh_q;
		bypass_d   = bypass_q;
		idSh_d     = idSh_q;
		bsrSh_d    = bsrSh_q;
		bsrDrive_d = bsrDrive_q;
		tdo_d      = tdo_q;
		tdoOeN_d   = tdoOeN_q;
		// no test clock edge needed; the pin is only two cycles late
		if (!pins.trstN)
		begin
			state_d  = S_TLR;
			ir_d     = INS_IDCODE;
			tdoOeN_d = 1'b1;
		end
		else
		begin
			if (pins.tckRise)
			begin
				state_d = stepState(state_q, pins.tms);
				case (state_q)
					S_TLR:
						ir_d = INS_IDCODE;
					S_CAPIR:
						irSh_d = IR_CAPTURE;
					S_SHIR:
						irSh_d = {pins.tdi, irSh_q[IR_W-1:1]};
					S_CAPDR:
					begin
						bypass_d = 1'b0;
						idSh_d   = ID_VALUE;
						bsrSh_d  = bsrSense;
					end
					S_SHDR:
					begin
						case (ir_q)
							INS_IDCODE:
								idSh_d = {pins.tdi, idSh_q[ID_W-1:1]};
							INS_SAMPLE,
							INS_EXTEST:
								bsrSh_d = {pins.tdi, bsrSh_q[BSR_W-1:1]};
							default:
								bypass_d = pins.tdi;
						endcase
					end
					default:
						;
				endcase
			end
			// updates land on the falling edge, as the scan cells expect
			if (pins.tckFall)
			begin
				if (state_q == S_UPIR)
				begin
					ir_d = irSh_q;
				end
				if (state_q == S_UPDR && (ir_q == INS_EXTEST ||
					ir_q == INS_SAMPLE))
				begin
					bsrDrive_d = bsrSh_q;
				end
				if (state_q == S_SHIR)
				begin
					tdo_d    = irSh_q[0];
					tdoOeN_d = 1'b0;
				end
				else if (state_q == S_SHDR)
				begin
					tdo_d    = drLsb;
					tdoOeN_d = 1'b0;
				end
				else
				begin
					tdoOeN_d = 1'b1;
				end
			end
		end
		extest_d = (ir_d == INS_EXTEST);
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_q    <= S_TLR;
			ir_q       <= INS_IDCODE;
			irSh_q     <= '0;
			bypass_q   <= 1'b0;
			idSh_q     <= '0;
			bsrSh_q    <= '0;
			bsrDrive_q <= '0;
			tdo_q      <= 1'b0;
			tdoOeN_q   <= 1'b1;
			extest_q   <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			ir_q       <= ir_d;
			irSh_q     <= irSh_d;
			bypass_q   <= bypass_d;
			idSh_q     <= idSh_d;
			bsrSh_q    <= bsrSh_d;
			bsrDrive_q <= bsrDrive_d;
			tdo_q      <= tdo_d;
			tdoOeN_q   <= tdoOeN_d;
			extest_q   <= extest_d;
		end
	end

	assign tdoOut       = tdo_q;
	assign tdoOeN       = tdoOeN_q;
	assign bsrDrive     = bsrDrive_q;
	assign extestActive = extest_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	chk_tdo_fall_edge: assert property (
		$changed(tdoOut) |-> $past(pins.tckFall))
		else $error("tdo changed away from a test clock fall");

	chk_tdo_release_idle: assert property (
		pins.tckFall && state_q != S_SHIR && state_q != S_SHDR
		|=> tdoOeN)
		else $error("tdo still driven outside a shift state");

	chk_trst_forces_reset: assert property (
		!pins.trstN |=> state_q == S_TLR && tdoOeN)
		else $error("test reset did not force the reset state");

	chk_tms_steers_fsm: assert property (
		pins.trstN && pins.tckRise && state_q == S_RTI
		|=> state_q == (pins.tms ? S_SELDR : S_RTI))
		else $error("idle state ignored mode select");

	chk_ir_shift_in: assert property (
		pins.trstN && pins.tckRise && state_q == S_SHIR
		|=> irSh_q[IR_W-1] == $past(pins.tdi))
		else $error("instruction shift lost the data in bit");

	chk_state_holds_still: assert property (
		pins.trstN && !pins.tckRise |=> $stable(state_q))
		else $error("state moved without a test clock rise");

	chk_state_one_hot: assert property (
		$onehot(state_q))
		else $error("state register is not one-hot");

	chk_capture_to_shift: assert property (
		pins.trstN && pins.tckRise && state_q == S_CAPIR && !pins.tms
		|=> state_q == S_SHIR && irSh_q == IR_CAPTURE)
		else $error("instruction capture did not load its pattern");

	cov_shift_ir: cover property (state_q == S_SHIR && !tdoOeN);
	cov_extest_update: cover property (
		state_q == S_UPDR && pins.tckFall && ir_q == INS_EXTEST);
	cov_trst_mid_scan: cover property (state_q == S_SHDR && !pins.trstN);
endmodule

// [bst_scan_ctl.sv]
// scan controller model that drives the test pins on its own timing
`timescale 1ns/100ps
module bst_scan_ctl
(
	// test pins toward the port
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      trstN,
	// three-state data back from the port
	input  wire logic tdoOut,
	input  wire logic tdoOeN
);
	int   edgeSlips;
	logic tdoWire;
	// no pull on data out: a released pin shows the inverse, not stale data
	assign tdoWire = tdoOeN ? ~tdoOut : tdoOut;
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		trstN = 1'b1;
		edgeSlips = 0;
	end
	// long low phase: data out lags the fall by up to 3 system clocks
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#8;
		q = tdoWire;
		tck = 1'b1;
		#24;
		tck = 1'b0;
		#16;
		if (tdoWire !== q)
			edgeSlips++;
		#16;
	endtask
	task automatic testReset();
		trstN = 1'b0;
		// whole clock periods keep later pin edges off the sampling edge
		#96;
		trstN = 1'b1;
		#40;
	endtask
	// from idle through capture, shift, update and back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b1, q);
		if (ir)
			step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask
endmodule

// [bst_tap_port_tb_top.sv]
// self-checking bench for the boundary scan test access port
`timescale 1ns/100ps
module bst_tap_port_tb_top
	import bst_pkg::*;
;
	logic               clk;
	logic               reset;
	logic [BSR_LEN-1:0] bsrSense;
	wire                tck;
	wire                tms;
	wire                tdi;
	wire                trstN;
	wire                tdoOut;
	wire                tdoOeN;
	wire  [BSR_LEN-1:0] bsrDrive;
	wire                extestActive;
	int                 num_errors;
	int                 checks_done;
	logic [31:0]        d;
	logic               q;

	bst_tap_port DUT
	(
		.clk          (clk),
		.reset        (reset),
		.tckPin       (tck),
		.tmsPin       (tms),
		.tdiPin       (tdi),
		.trstPinN     (trstN),
		.tdoOut       (tdoOut),
		.tdoOeN       (tdoOeN),
		.bsrSense     (bsrSense),
		.bsrDrive     (bsrDrive),
		.extestActive (extestActive)
	);
	bst_scan_ctl ctl
	(
		.tck    (tck),
		.tms    (tms),
		.tdi    (tdi),
		.trstN  (trstN),
		.tdoOut (tdoOut),
		.tdoOeN (tdoOeN)
	);

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic end_sim();
		$display("checks %0d, errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// values are taken at the call, once the step that made them has ended
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		repeat (3) @(negedge clk);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic idScan();
		ctl.testReset();
		ctl.step(1'b0, 1'b1, q);
		chk(tdoOeN, 1'b1);
		ctl.scan(1'b1, IR_W, INS_IDCODE, d);
		chk(d[IR_W-1:0], IR_CAPTURE);
		ctl.scan(1'b0, ID_W, 32'h0, d);
		chk(d, ID_DEFAULT);
		chk(tdoOeN, 1'b1);
	endtask

	// documented and undocumented codes both select the one-bit path
	task automatic bypassScan();
		logic [IR_W-1:0] codes [2];
		codes = '{INS_BYPASS, 4'h5};
		foreach (codes[k])
		begin
			ctl.scan(1'b1, IR_W, codes[k], d);
			ctl.scan(1'b0, 9, 32'h1a5, d);
			chk(d[8:0], 9'h14a);
			chk(extestActive, 1'b0);
		end
	endtask

	task automatic boundaryScan();
		@(posedge clk);
		bsrSense <= 8'h5a;
		// back to the falling edge so pin edges never meet a sampling edge
		@(negedge clk);
		ctl.scan(1'b1, IR_W, INS_SAMPLE, d);
		ctl.scan(1'b0, BSR_LEN, 32'hc3, d);
		chk(d[BSR_LEN-1:0], 8'h5a);
		chk(bsrDrive, 8'hc3);
		chk(extestActive, 1'b0);
		ctl.scan(1'b1, IR_W, INS_EXTEST, d);
		chk(extestActive, 1'b1);
		ctl.scan(1'b0, BSR_LEN, 32'h3c, d);
		chk(d[BSR_LEN-1:0], 8'h5a);
		chk(bsrDrive, 8'h3c);
	endtask

	// five high mode-select clocks reach the reset state from anywhere
	task automatic tmsReset();
		repeat (5) ctl.step(1'b1, 1'b1, q);
		chk(extestActive, 1'b0);
	endtask

	// test reset in mid-shift, with the test clock standing still
	task automatic trstAbort();
		ctl.step(1'b0, 1'b1, q);
		ctl.scan(1'b1, IR_W, INS_EXTEST, d);
		ctl.step(1'b1, 1'b1, q);
		ctl.step(1'b0, 1'b1, q);
		ctl.step(1'b0, 1'b1, q);
		chk(tdoOeN, 1'b0);
		ctl.testReset();
		chk(tdoOeN, 1'b1);
		chk(extestActive, 1'b0);
		ctl.step(1'b0, 1'b1, q);
		ctl.scan(1'b0, ID_W, 32'h0, d);
		chk(d, ID_DEFAULT);
	endtask

	initial
	begin
		num_errors = 0;
		checks_done = 0;
		reset = 1'b1;
		bsrSense = '0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		chk(tdoOeN, 1'b1);
		chk(bsrDrive, 8'h00);
		idScan();
		bypassScan();
		boundaryScan();
		tmsReset();
		trstAbort();
		chk(ctl.edgeSlips, 32'h0);
		end_sim();
	end

	// cut a hang short
	initial
	begin
		#200000;
		num_errors++;
		end_sim();
	end
endmodule
